// file: src/gyro_rate_regs.sv
// Top: x and y rate registers plus error flags on a 16-bit register port.
// Assumes the serial front end delivers address and a one-cycle read strobe.
`timescale 1ns/10ps
module gyro_rate_regs #(
  parameter rate_regs_pkg::range_variant_t RANGE = rate_regs_pkg::RANGE_SMALL
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic rd_strobe,
  input wire logic [6:0] rd_addr,
  output logic [15:0] rd_data,
  output logic rd_valid,
  input wire logic [15:0] global_command,
  input wire logic global_command_wr,
  input wire logic flash_update_done,
  input wire logic flash_update_ok,
  input wire logic overrun_event,
  input wire logic sample_valid,
  input wire logic [31:0] x_sample,
  input wire logic [31:0] y_sample,
  output logic [1:0] range_code,
  output logic flash_update_start,
  output logic soft_reset
);
  flag_if fl ();
  logic [15:0] x_high;
  logic [15:0] x_low;
  logic [15:0] y_high;
  logic [15:0] y_low;
  logic [15:0] rd_data_ff;
  logic [15:0] nxt_rd_data;
  logic rd_valid_ff;
  logic nxt_rd_valid;
  logic flash_busy_ff;
  logic nxt_flash_busy;
  logic flash_start_ff;
  logic nxt_flash_start;
  logic soft_reset_ff;
  logic nxt_soft_reset;

  // Even-byte decode: either byte of a word selects it
  function automatic logic [6:0] word_addr(input logic [6:0] a);
    word_addr = {a[6:1], 1'b0};
  endfunction

  // Map hit test, used by the unmapped-read check below
  function automatic logic is_mapped(input logic [6:0] a);
    logic [6:0] w;
    w = word_addr(a);
    is_mapped = (w == rate_regs_pkg::ERR_FLAGS_ADDR) || (w == rate_regs_pkg::X_LOW_ADDR) ||
      (w == rate_regs_pkg::X_HIGH_ADDR) || (w == rate_regs_pkg::Y_LOW_ADDR) ||
      (w == rate_regs_pkg::Y_HIGH_ADDR);
  endfunction

  error_flags_reg u_flags (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .fl(fl)
  );

  rate_axis_reg #(.SAMPLE_W(32)) u_x (
    .clock(clock),
    .ce(ce),
    .sample_valid(sample_valid),
    .sample(x_sample),
    .high_word(x_high),
    .low_word(x_low)
  );

  rate_axis_reg #(.SAMPLE_W(32)) u_y (
    .clock(clock),
    .ce(ce),
    .sample_valid(sample_valid),
    .sample(y_sample),
    .high_word(y_high),
    .low_word(y_low)
  );

  // Scale is fixed by the variant; the host reads the code to pick the LSB weight
  assign range_code = RANGE;

  always_comb begin
    nxt_rd_valid = rd_strobe;
    nxt_rd_data = rd_data_ff;
    if (rd_strobe) begin
      unique case (word_addr(rd_addr))
        rate_regs_pkg::ERR_FLAGS_ADDR: nxt_rd_data = fl.flags;
        rate_regs_pkg::X_LOW_ADDR: nxt_rd_data = x_low;
        rate_regs_pkg::X_HIGH_ADDR: nxt_rd_data = x_high;
        rate_regs_pkg::Y_LOW_ADDR: nxt_rd_data = y_low;
        rate_regs_pkg::Y_HIGH_ADDR: nxt_rd_data = y_high;
        default: nxt_rd_data = rate_regs_pkg::UNMAPPED_DATA;
      endcase
    end
  end

  // Read returns the pre-clear value, clear takes effect on the same edge
  assign fl.read_clear = ce && rd_strobe &&
    (word_addr(rd_addr) == rate_regs_pkg::ERR_FLAGS_ADDR);

  always_comb begin
    nxt_flash_busy = flash_busy_ff;
    nxt_flash_start = 1'b0;
    nxt_soft_reset = 1'b0;
    if (global_command_wr && global_command[rate_regs_pkg::CMD_FLASH_UPDATE_BIT]) begin
      nxt_flash_busy = 1'b1;
      nxt_flash_start = 1'b1;
    end else if (flash_update_done) begin
      nxt_flash_busy = 1'b0;
    end
    if (global_command_wr && global_command[rate_regs_pkg::CMD_RESET_BIT]) begin
      nxt_soft_reset = 1'b1;
    end
  end

  // Only a completion of an update we started counts
  assign fl.flash_fail_set = flash_busy_ff && flash_update_done && !flash_update_ok;
  assign fl.overrun_set = overrun_event;
  assign fl.overrun_clear = soft_reset_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data_ff <= 16'h0000;
      rd_valid_ff <= 1'b0;
      flash_busy_ff <= 1'b0;
      flash_start_ff <= 1'b0;
      soft_reset_ff <= 1'b0;
    end else if (ce) begin
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
      flash_busy_ff <= nxt_flash_busy;
      flash_start_ff <= nxt_flash_start;
      soft_reset_ff <= nxt_soft_reset;
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;
  assign flash_update_start = flash_start_ff;
  assign soft_reset = soft_reset_ff;

  property p_read_x_high;
    @(posedge clock) disable iff (rst)
      ce && rd_strobe && word_addr(rd_addr) == rate_regs_pkg::X_HIGH_ADDR
      |=> rd_valid && rd_data == $past(x_high);
  endproperty
  a_read_x_high: assert property (p_read_x_high) else $error("x high read wrong");

  property p_read_y_low;
    @(posedge clock) disable iff (rst)
      ce && rd_strobe && word_addr(rd_addr) == rate_regs_pkg::Y_LOW_ADDR
      |=> rd_data == $past(y_low);
  endproperty
  a_read_y_low: assert property (p_read_y_low) else $error("y low read wrong");

  property p_flag_read_then_clear;
    @(posedge clock) disable iff (rst)
      ce && fl.read_clear && !fl.flash_fail_set && !fl.overrun_set && !soft_reset_ff
      && !fl.flags[1]
      |=> rd_data == $past(fl.flags) && fl.flags == 16'h0000;
  endproperty
  a_flag_read_then_clear: assert property (p_flag_read_then_clear)
    else $error("flag read not clear-on-read");

  // Completion may come a few cycles after the command, never sooner than one
  property p_flash_fail_path;
    @(posedge clock) disable iff (rst)
      ce && global_command_wr && global_command[rate_regs_pkg::CMD_FLASH_UPDATE_BIT]
      ##[1:8] ce && flash_update_done && !flash_update_ok
      |=> fl.flags[rate_regs_pkg::FLASH_FAIL_BIT];
  endproperty
  a_flash_fail_path: assert property (p_flash_fail_path)
    else $error("flash failure missed");

  property p_flash_needs_done;
    @(posedge clock) disable iff (rst)
      ce && !fl.flags[rate_regs_pkg::FLASH_FAIL_BIT] && !flash_update_done
      |=> !fl.flags[rate_regs_pkg::FLASH_FAIL_BIT];
  endproperty
  a_flash_needs_done: assert property (p_flash_needs_done)
    else $error("flash flag rose without completion");

  property p_flash_ok_no_flag;
    @(posedge clock) disable iff (rst)
      ce && flash_update_done && flash_update_ok && !fl.flags[rate_regs_pkg::FLASH_FAIL_BIT]
      |=> !fl.flags[rate_regs_pkg::FLASH_FAIL_BIT];
  endproperty
  a_flash_ok_no_flag: assert property (p_flash_ok_no_flag)
    else $error("successful update flagged");

  property p_overrun_needs_event;
    @(posedge clock) disable iff (rst)
      ce && !fl.flags[rate_regs_pkg::OVERRUN_BIT] && !overrun_event
      |=> !fl.flags[rate_regs_pkg::OVERRUN_BIT];
  endproperty
  a_overrun_needs_event: assert property (p_overrun_needs_event)
    else $error("overrun flag rose without event");

  // After the reset command the next flag read leaves the overrun bit low
  property p_cmd_clears_overrun;
    @(posedge clock) disable iff (rst)
      ce && soft_reset && !overrun_event ##1 ce && fl.read_clear && !overrun_event
      |=> !fl.flags[rate_regs_pkg::OVERRUN_BIT];
  endproperty
  a_cmd_clears_overrun: assert property (p_cmd_clears_overrun)
    else $error("overrun survived reset command");

  property p_read_x_low;
    @(posedge clock) disable iff (rst)
      ce && rd_strobe && word_addr(rd_addr) == rate_regs_pkg::X_LOW_ADDR
      |=> rd_valid && rd_data == $past(x_low);
  endproperty
  a_read_x_low: assert property (p_read_x_low)
    else $error("x low read wrong");

  property p_read_y_high;
    @(posedge clock) disable iff (rst)
      ce && rd_strobe && word_addr(rd_addr) == rate_regs_pkg::Y_HIGH_ADDR
      |=> rd_valid && rd_data == $past(y_high);
  endproperty
  a_read_y_high: assert property (p_read_y_high)
    else $error("y high read wrong");

  property p_read_flags;
    @(posedge clock) disable iff (rst)
      ce && rd_strobe && word_addr(rd_addr) == rate_regs_pkg::ERR_FLAGS_ADDR
      |=> rd_valid && rd_data == $past(fl.flags);
  endproperty
  a_read_flags: assert property (p_read_flags)
    else $error("flag read wrong");

  property p_read_unmapped;
    @(posedge clock) disable iff (rst)
      ce && rd_strobe && !is_mapped(rd_addr)
      |=> rd_valid && rd_data == rate_regs_pkg::UNMAPPED_DATA;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("unmapped read not zero");

  // Host relies on the valid pulse being exactly one cycle
  property p_valid_idle;
    @(posedge clock) disable iff (rst)
      ce && !rd_strobe |=> !rd_valid;
  endproperty
  a_valid_idle: assert property (p_valid_idle)
    else $error("valid without read");

  property p_data_hold;
    @(posedge clock) disable iff (rst)
      !(ce && rd_strobe) |=> $stable(rd_data);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("read data moved without read");

  property p_frozen;
    @(posedge clock) disable iff (rst)
      !ce |=> $stable(fl.flags) && $stable(rd_valid) && $stable(flash_update_start);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("state moved while frozen");

  property p_flash_start;
    @(posedge clock) disable iff (rst)
      ce && global_command_wr && global_command[rate_regs_pkg::CMD_FLASH_UPDATE_BIT]
      |=> flash_update_start;
  endproperty
  a_flash_start: assert property (p_flash_start)
    else $error("flash update not started");

  property p_start_idle;
    @(posedge clock) disable iff (rst)
      ce && !global_command_wr |=> !flash_update_start;
  endproperty
  a_start_idle: assert property (p_start_idle)
    else $error("flash start without command");

  property p_soft_reset;
    @(posedge clock) disable iff (rst)
      ce && global_command_wr && global_command[rate_regs_pkg::CMD_RESET_BIT]
      |=> soft_reset;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("reset command not pulsed");

  property p_soft_idle;
    @(posedge clock) disable iff (rst)
      ce && !global_command_wr |=> !soft_reset;
  endproperty
  a_soft_idle: assert property (p_soft_idle)
    else $error("reset pulse without command");
endmodule

// file: inc/rate_regs_pkg.sv
// Package: register map, flag positions and sample format constants.
// Assumes a 16-bit register word addressed by even byte address.
package rate_regs_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 7;
  localparam logic [6:0] ERR_FLAGS_ADDR = 7'h02;
  localparam logic [6:0] X_LOW_ADDR = 7'h04;
  localparam logic [6:0] X_HIGH_ADDR = 7'h06;
  localparam logic [6:0] Y_LOW_ADDR = 7'h08;
  localparam logic [6:0] Y_HIGH_ADDR = 7'h0A;
  localparam logic [15:0] ERR_FLAGS_RESET = 16'h0000;
  localparam int FLASH_FAIL_BIT = 2;
  localparam int OVERRUN_BIT = 1;
  localparam int CMD_FLASH_UPDATE_BIT = 3;
  localparam int CMD_RESET_BIT = 7;
  localparam logic [15:0] FULL_POS_COUNT = 16'h4E20;
  localparam logic [15:0] FULL_NEG_COUNT = 16'hB1E0;
  localparam logic [15:0] UNMAPPED_DATA = 16'h0000;
  typedef enum logic [1:0] {
    RANGE_SMALL = 2'b00,
    RANGE_MIDDLE = 2'b01,
    RANGE_LARGE = 2'b10
  } range_variant_t;
endpackage

// file: inc/flag_if.sv
// Interface: error event and clear lines between top and flag module.
// Assumes one clock domain shared by both ends.
`timescale 1ns/10ps
interface flag_if;
  logic flash_fail_set;
  logic overrun_set;
  logic overrun_clear;
  logic read_clear;
  logic [15:0] flags;
  modport top (output flash_fail_set, output overrun_set, output overrun_clear,
    output read_clear, input flags);
  modport flagger (input flash_fail_set, input overrun_set, input overrun_clear,
    input read_clear, output flags);
endinterface

// file: src/error_flags_reg.sv
// Sticky, clear-on-read error flag register.
// Assumes event inputs are on the same clock as the register.
`timescale 1ns/10ps
module error_flags_reg (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  flag_if.flagger fl
);
  logic [15:0] flags_ff;
  logic [15:0] nxt_flags;
  logic overrun_cond_ff;
  logic nxt_overrun_cond;

  always_comb begin
    nxt_flags = flags_ff;
    nxt_overrun_cond = overrun_cond_ff;
    if (fl.read_clear) begin
      nxt_flags = rate_regs_pkg::ERR_FLAGS_RESET;
    end
    if (fl.overrun_clear) begin
      nxt_overrun_cond = 1'b0;
    end else if (fl.overrun_set) begin
      nxt_overrun_cond = 1'b1;
    end
    // Set beats read clear; a standing overrun re-raises after a read
    if (fl.flash_fail_set) begin
      nxt_flags[rate_regs_pkg::FLASH_FAIL_BIT] = 1'b1;
    end
    if ((fl.overrun_set || overrun_cond_ff) && !fl.overrun_clear) begin
      nxt_flags[rate_regs_pkg::OVERRUN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flags_ff <= rate_regs_pkg::ERR_FLAGS_RESET;
      overrun_cond_ff <= 1'b0;
    end else if (ce) begin
      flags_ff <= nxt_flags;
      overrun_cond_ff <= nxt_overrun_cond;
    end
  end

  assign fl.flags = flags_ff;

  // Flag bits that hardware may raise; all others read as zero
  localparam logic [15:0] USED_MASK = (16'h0001 << rate_regs_pkg::FLASH_FAIL_BIT) |
    (16'h0001 << rate_regs_pkg::OVERRUN_BIT);

  property p_sticky;
    @(posedge clock) disable iff (rst)
      ce && !fl.read_clear |=> (flags_ff & $past(flags_ff)) == $past(flags_ff);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without read");

  property p_read_clears;
    @(posedge clock) disable iff (rst)
      ce && fl.read_clear && !fl.flash_fail_set |=> !flags_ff[rate_regs_pkg::FLASH_FAIL_BIT];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear");

  property p_flash_set;
    @(posedge clock) disable iff (rst)
      ce && fl.flash_fail_set |=> flags_ff[rate_regs_pkg::FLASH_FAIL_BIT];
  endproperty
  a_flash_set: assert property (p_flash_set) else $error("flash failure not flagged");

  property p_reraise;
    @(posedge clock) disable iff (rst)
      ce && overrun_cond_ff && fl.read_clear && !fl.overrun_clear
      |=> flags_ff[rate_regs_pkg::OVERRUN_BIT];
  endproperty
  a_reraise: assert property (p_reraise) else $error("overrun not re-raised");

  property p_overrun_set;
    @(posedge clock) disable iff (rst)
      ce && fl.overrun_set && !fl.overrun_clear
      |=> flags_ff[rate_regs_pkg::OVERRUN_BIT] && overrun_cond_ff;
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun not flagged");

  property p_reserved_zero;
    @(posedge clock) disable iff (rst) (flags_ff & ~USED_MASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved flag set");
endmodule

// file: src/rate_axis_reg.sv
// One rate axis: high and low words captured together from one sample.
// Assumes sample_valid is a one-cycle strobe on the same clock.
`timescale 1ns/10ps
module rate_axis_reg #(
  parameter int SAMPLE_W = 32
) (
  input wire logic clock,
  input wire logic ce,
  input wire logic sample_valid,
  input wire logic [SAMPLE_W-1:0] sample,
  output logic [15:0] high_word,
  output logic [15:0] low_word
);
  logic [SAMPLE_W-1:0] sample_ff;
  logic [SAMPLE_W-1:0] nxt_sample;

  always_comb begin
    nxt_sample = sample_ff;
    if (sample_valid) begin
      nxt_sample = sample;
    end
  end

  // No reset: power-up value is undefined by design
  always_ff @(posedge clock) begin
    if (ce) begin
      sample_ff <= nxt_sample;
    end
  end

  assign high_word = sample_ff[SAMPLE_W-1:SAMPLE_W-16];
  assign low_word = sample_ff[SAMPLE_W-17:SAMPLE_W-32];

  property p_coherent;
    @(posedge clock) ce && sample_valid |=> {high_word, low_word} == $past(sample);
  endproperty
  a_coherent: assert property (p_coherent) else $error("words not from one sample");

  property p_hold;
    @(posedge clock) !sample_valid |=> $stable(sample_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("sample changed without strobe");
endmodule

// file: verif/flash_stub.sv
// Partner model: flash storage that finishes an update some cycles after start.
// Assumes start is a one-cycle pulse on the device clock.
`timescale 1ns/10ps
module flash_stub (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic fail,
  output logic done,
  output logic ok
);
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic tog_ff;
  always_comb begin
    nxt_cnt = cnt_ff;
    if (start) begin
      nxt_cnt = 3'h4;
    end else if (cnt_ff != 3'h0) begin
      nxt_cnt = cnt_ff - 3'h1;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_ff <= 3'h0;
      tog_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tog_ff <= ~tog_ff;
    end
  end
  assign done = (cnt_ff == 3'h1);
  // Outside the done pulse ok is junk, so a design must not look at it then
  assign ok = done ? ~fail : tog_ff;
endmodule

// file: verif/testbench.sv
// Self-checking bench for the rate and error flag registers.
// Assumes the flash partner model and the design sources are compiled first.
`timescale 1ns/10ps
module testbench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic rd_strobe = 1'b0;
  logic [6:0] rd_addr = 7'h00;
  logic [15:0] rd_data;
  logic rd_valid;
  logic [15:0] global_command = 16'h0000;
  logic global_command_wr = 1'b0;
  logic done;
  logic ok;
  logic overrun_event = 1'b0;
  logic sample_valid = 1'b0;
  logic [31:0] x_sample = 32'h0;
  logic [31:0] y_sample = 32'h0;
  logic [1:0] range_code;
  logic start;
  logic soft_reset;
  logic fail = 1'b0;
  logic ce = 1'b1;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  logic [15:0] d;
  gyro_rate_regs dut (.clock(clock), .rst(rst), .ce(ce), .rd_strobe(rd_strobe),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .global_command(global_command), .global_command_wr(global_command_wr),
    .flash_update_done(done), .flash_update_ok(ok), .overrun_event(overrun_event),
    .sample_valid(sample_valid), .x_sample(x_sample), .y_sample(y_sample),
    .range_code(range_code), .flash_update_start(start), .soft_reset(soft_reset));
  flash_stub flash (.clock(clock), .rst(rst), .start(start), .fail(fail), .done(done),
    .ok(ok));
  always #10 clock = ~clock;
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Hang guard: whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    @(posedge clock);
    rd_strobe <= 1'b1;
    rd_addr <= a;
    @(posedge clock);
    rd_strobe <= 1'b0;
    #1;
    check("rd_valid", {15'h0000, rd_valid}, 16'h0001);
    v = rd_data;
  endtask
  task automatic cmd(input logic [15:0] v);
    @(posedge clock);
    global_command <= v;
    global_command_wr <= 1'b1;
    @(posedge clock);
    global_command_wr <= 1'b0;
    #1;
    check("soft_reset", {15'h0000, soft_reset}, {15'h0000, v[7]});
    check("flash start", {15'h0000, start}, {15'h0000, v[3]});
  endtask
  task automatic test_reset_map();
    rd(rate_regs_pkg::ERR_FLAGS_ADDR, d);
    check("flags after reset", d, rate_regs_pkg::ERR_FLAGS_RESET);
    rd(7'h40, d);
    check("unmapped", d, 16'h0000);
    check("range", {14'h0000, range_code}, 16'h0000);
  endtask
  task automatic test_samples();
    @(posedge clock);
    x_sample <= 32'h4E20_1234;
    y_sample <= 32'hB1E0_ABCD;
    sample_valid <= 1'b1;
    @(posedge clock);
    sample_valid <= 1'b0;
    // New values without a strobe must not leak into the words
    x_sample <= 32'h0001_FFFF;
    y_sample <= 32'hFFFF_0001;
    rd(7'h05, d);
    check("x low", d, 16'h1234);
    rd(7'h06, d);
    check("x high", d, 16'h4E20);
    rd(7'h08, d);
    check("y low", d, 16'hABCD);
    rd(7'h0B, d);
    check("y high", d, rate_regs_pkg::FULL_NEG_COUNT);
    rd(7'h04, d);
    check("x low held", d, 16'h1234);
    rd(7'h07, d);
    check("x high odd byte", d, rate_regs_pkg::FULL_POS_COUNT);
    rd(7'h09, d);
    check("y low odd byte", d, 16'hABCD);
    rd(7'h0A, d);
    check("y high even byte", d, 16'hB1E0);
    // Sample of minus one: both words all ones
    @(posedge clock);
    x_sample <= 32'hFFFF_FFFF;
    sample_valid <= 1'b1;
    @(posedge clock);
    sample_valid <= 1'b0;
    rd(7'h06, d);
    check("x high minus one", d, 16'hFFFF);
    rd(7'h04, d);
    check("x low minus one", d, 16'hFFFF);
  endtask
  task automatic test_freeze();
    // Strobes while frozen must leave every register untouched
    @(posedge clock);
    ce <= 1'b0;
    x_sample <= 32'h1111_2222;
    sample_valid <= 1'b1;
    rd_strobe <= 1'b1;
    rd_addr <= rate_regs_pkg::X_LOW_ADDR;
    @(posedge clock);
    sample_valid <= 1'b0;
    rd_strobe <= 1'b0;
    #1;
    check("rd_valid frozen", {15'h0000, rd_valid}, 16'h0000);
    @(posedge clock);
    ce <= 1'b1;
    rd(7'h04, d);
    check("x low frozen", d, 16'hFFFF);
  endtask
  task automatic test_mid_reset();
    @(posedge clock);
    overrun_event <= 1'b1;
    @(posedge clock);
    overrun_event <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    check("rd_data after reset", rd_data, 16'h0000);
    rd(rate_regs_pkg::ERR_FLAGS_ADDR, d);
    check("overrun cleared by reset", d, 16'h0000);
  endtask
  task automatic test_overrun();
    @(posedge clock);
    overrun_event <= 1'b1;
    @(posedge clock);
    overrun_event <= 1'b0;
    repeat (3) @(posedge clock);
    rd(7'h02, d);
    check("overrun flag", d, 16'h0002);
    rd(7'h02, d);
    check("overrun again", d, 16'h0002);
    cmd(16'h0080);
    rd(7'h02, d);
    check("flag sticky", d, 16'h0002);
    rd(7'h03, d);
    check("overrun cleared", d, 16'h0000);
  endtask
  task automatic test_flash(input logic bad);
    int n;
    fail = bad;
    cmd(16'h0008);
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("flash done seen", {15'h0000, done}, 16'h0001);
    rd(7'h02, d);
    check("flash flag", d, {13'h0000, bad, 2'b00});
    rd(7'h02, d);
    check("flash flag read clear", d, 16'h0000);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    test_reset_map();
    test_samples();
    test_freeze();
    test_overrun();
    test_flash(1'b1);
    test_flash(1'b0);
    test_mid_reset();
    tally_and_finish();
  end
endmodule
